// >>> level_limit_timer.sv
// level limit timer: 8-bit counter, level external reset, pwm time base
// assumes wishbone classic master on clk_i; external reset is asynchronous
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/10ps

module level_limit_timer
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [4:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// external signals
	input  wire logic        external_reset_input_i,
	output logic             pwm_o,
	output logic             period_match_o
);
	logic [7:0] count_q;
	logic [7:0] period_q;
	logic [7:0] control_q;
	logic [7:0] limit_mode_q;
	logic [7:0] clk_sel_q;
	logic [7:0] rst_sel_q;
	logic [7:0] pulse_q;
	logic       ers_m_q;
	logic       ers_s_q;
	logic [1:0] act_cnt_q;
	logic [1:0] rel_cnt_q;
	logic       held_q;
	logic [7:0] pre_q;
	logic       tick;
	logic       timer_on;
	logic       level_mode;
	logic       ers_active;
	logic       bus_req;
	logic       wr;
	logic       cpu_count_wr;
	logic [4:0] mode;

	assign bus_req  = cyc_i & stb_i;
	// a write lands on the edge at which the master samples ack high
	assign wr       = bus_req & we_i & sel_i[0] & ack_o;
	assign timer_on = control_q[hlt_pkg::ctl_on_bit];
	assign mode     = limit_mode_q[hlt_pkg::mode_lsb +: 5];
	assign level_mode = (mode == hlt_pkg::mode_level_low) |
		(mode == hlt_pkg::mode_level_high);
	assign cpu_count_wr = wr & (adr_i == hlt_pkg::off_count);

	// pin crosses into clk_i domain before any logic looks at it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ers_m_q <= 1'b0;
			ers_s_q <= 1'b0;
		end
		else
		begin
			ers_m_q <= external_reset_input_i;
			ers_s_q <= ers_m_q;
		end
	end

	// level select; when off ers_active stays low, but status still reports the synced input
	always_comb
	begin
		ers_active = 1'b0;
		if (timer_on && mode == hlt_pkg::mode_level_low)
			ers_active = ~ers_s_q;
		else if (timer_on && mode == hlt_pkg::mode_level_high)
			ers_active = ers_s_q;
	end

	// held_q sets two clocks after active, clears two after release
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !level_mode)
		begin
			act_cnt_q <= 2'd0;
			rel_cnt_q <= 2'd0;
			held_q    <= 1'b0;
		end
		else if (ers_active)
		begin
			rel_cnt_q <= 2'd0;
			if (act_cnt_q == 2'(hlt_pkg::ers_delay_cycles - 1))
				held_q <= 1'b1;
			else
				act_cnt_q <= act_cnt_q + 2'd1;
		end
		else
		begin
			act_cnt_q <= 2'd0;
			if (rel_cnt_q == 2'(hlt_pkg::ers_delay_cycles - 1))
				held_q <= 1'b0;
			else if (held_q)
				rel_cnt_q <= rel_cnt_q + 2'd1;
		end
	end

	// prescaler: one-cycle tick every 2^ckps clocks
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !timer_on)
			pre_q <= 8'h00;
		else
			pre_q <= pre_q + 8'h01;
	end

	always_comb
	begin
		tick = 1'b1;
		case (control_q[hlt_pkg::ctl_ckps_lsb +: 3])
			3'd0:    tick = 1'b1;
			default: tick = (pre_q & ((8'h01 <<
				control_q[hlt_pkg::ctl_ckps_lsb +: 3]) - 8'h01)) == 8'h00;
		endcase
	end

	// counter
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			count_q        <= hlt_pkg::count_rst;
			period_match_o <= 1'b0;
		end
		else
		begin
			period_match_o <= 1'b0;
			if (cpu_count_wr)
				count_q <= dat_i[7:0];
			else if (held_q)
				count_q <= 8'h00;
			else if (timer_on && tick)
			begin
				if (count_q == period_q)
				begin
					count_q        <= 8'h00;
					period_match_o <= 1'b1;
				end
				else
					count_q <= count_q + 8'h01;
			end
		end
	end

	// pwm: high at restart, low on compare, untouched while held
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !timer_on)
			pwm_o <= 1'b0;
		else if (held_q)
			pwm_o <= pwm_o;
		else if (tick && count_q == period_q)
			pwm_o <= 1'b1;
		else if (count_q == pulse_q)
			pwm_o <= 1'b0;
	end

	// registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			period_q     <= hlt_pkg::period_rst;
			control_q    <= hlt_pkg::control_rst;
			limit_mode_q <= hlt_pkg::limit_mode_rst;
			clk_sel_q    <= hlt_pkg::clk_sel_rst;
			rst_sel_q    <= hlt_pkg::rst_sel_rst;
			pulse_q      <= hlt_pkg::pulse_rst;
		end
		else if (wr)
		begin
			case (adr_i)
				hlt_pkg::off_period:       period_q     <= dat_i[7:0];
				hlt_pkg::off_control:      control_q    <= dat_i[7:0];
				hlt_pkg::off_limit_mode:   limit_mode_q <= dat_i[7:0];
				hlt_pkg::off_clock_select: clk_sel_q    <= dat_i[7:0];
				hlt_pkg::off_reset_select: rst_sel_q    <= dat_i[7:0];
				hlt_pkg::off_pulse_width:  pulse_q      <= dat_i[7:0];
				default: ;
			endcase
		end
	end

	// ack one cycle after the request is taken; unmapped reads return zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= bus_req & ~ack_o;
			dat_o <= 32'h0000_0000;
			case (adr_i)
				hlt_pkg::off_count:        dat_o[7:0] <= count_q;
				hlt_pkg::off_period:       dat_o[7:0] <= period_q;
				hlt_pkg::off_control:      dat_o[7:0] <= control_q;
				hlt_pkg::off_limit_mode:   dat_o[7:0] <= limit_mode_q;
				hlt_pkg::off_clock_select: dat_o[7:0] <= {4'h0, clk_sel_q[3:0]};
				hlt_pkg::off_reset_select: dat_o[7:0] <= {4'h0, rst_sel_q[3:0]};
				hlt_pkg::off_pulse_width:  dat_o[7:0] <= pulse_q;
				hlt_pkg::off_status:
					dat_o[2:0] <= {held_q, ers_s_q, pwm_o};
				default: ;
			endcase
		end
	end
endmodule : level_limit_timer

// >>> hlt_pkg.sv
// level limit timer: register map, field layout and reset values
// assumes a 32-bit classic wishbone register bus, one word per register
package hlt_pkg;
	localparam logic [4:0] off_count        = 5'h00;
	localparam logic [4:0] off_period       = 5'h04;
	localparam logic [4:0] off_control      = 5'h08;
	localparam logic [4:0] off_limit_mode   = 5'h0C;
	localparam logic [4:0] off_clock_select = 5'h10;
	localparam logic [4:0] off_reset_select = 5'h14;
	localparam logic [4:0] off_pulse_width  = 5'h18;
	localparam logic [4:0] off_status       = 5'h1C;

	// timer_control fields
	localparam int ctl_on_bit     = 7;
	localparam int ctl_ckps_lsb   = 4;
	// timer_limit_mode fields
	localparam int mode_lsb       = 0;
	localparam logic [4:0] mode_level_low  = 5'h06;
	localparam logic [4:0] mode_level_high = 5'h07;

	localparam logic [7:0] count_rst      = 8'h00;
	localparam logic [7:0] period_rst     = 8'hFF;
	localparam logic [7:0] control_rst    = 8'h00;
	localparam logic [7:0] limit_mode_rst = 8'h00;
	localparam logic [7:0] clk_sel_rst    = 8'h00;
	localparam logic [7:0] rst_sel_rst    = 8'h00;
	localparam logic [7:0] pulse_rst      = 8'h00;

	// cycles the reset level must stand before acting, and after release
	localparam int ers_delay_cycles = 2;
endpackage : hlt_pkg

// >>> hlt_sva.sv
// port checker for the level limit timer
// assumes bus writes land no later than the edge that samples ack
`timescale 1ns/10ps
module hlt_sva
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [4:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic        ack_o,
	input wire logic        external_reset_input_i,
	input wire logic        pwm_o,
	input wire logic        period_match_o
);
	logic       on_q;
	logic [4:0] mode_q;
	wire wr = cyc_i & stb_i & we_i & ack_o & sel_i[0];
	wire lo = on_q & mode_q == hlt_pkg::mode_level_low & !external_reset_input_i;
	wire hi = on_q & mode_q == hlt_pkg::mode_level_high & external_reset_input_i;
	always_ff @(posedge clk_i)
		if (rst_i) on_q <= 1'b0;
		else if (wr && adr_i == hlt_pkg::off_control) on_q <= dat_i[7];
	always_ff @(posedge clk_i)
		if (rst_i) mode_q <= 5'h00;
		else if (wr && adr_i == hlt_pkg::off_limit_mode) mode_q <= dat_i[4:0];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_one; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack late");
	property p_ack_drop; ack_o |=> !ack_o; endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack too long");
	property p_off_pwm; !on_q [*2] |-> !pwm_o; endproperty
	a_off_pwm: assert property (p_off_pwm) else $error("pwm while off");
	property p_low_hold; lo [*6] |-> !period_match_o; endproperty
	a_low_hold: assert property (p_low_hold) else $error("low hold");
	property p_high_hold; hi [*6] |-> !period_match_o; endproperty
	a_high_hold: assert property (p_high_hold) else $error("high hold");
	property p_pwm_hold; (lo || hi) [*6] ##0 pwm_o |=> pwm_o; endproperty
	a_pwm_hold: assert property (p_pwm_hold) else $error("pwm dropped");
	property p_match_pwm; period_match_o |-> pwm_o; endproperty
	a_match_pwm: assert property (p_match_pwm) else $error("pwm low");
	// bench never programs a zero period, which would match every tick
	property p_match_gap; period_match_o |=> !period_match_o; endproperty
	a_match_gap: assert property (p_match_gap) else $error("match twice");
	c_match: cover property (period_match_o);
	c_fall: cover property ($fell(pwm_o));
	c_hold: cover property ((lo || hi) [*6] ##0 pwm_o);
endmodule : hlt_sva

// >>> hlt_ers_src.sv
// external reset source driving the timer's reset input
// assumes the bench says when the reset is active and at which level
`timescale 1ns/10ps
module hlt_ers_src
(
	input  wire logic clk_i,
	input  wire logic active_i,
	input  wire logic high_i,
	output logic      ers_o
);
	always_ff @(posedge clk_i) ers_o <= active_i ? high_i : !high_i;
endmodule : hlt_ers_src

// >>> level_limit_timer_test.sv
// self-checking bench for the level limit timer
// assumes a one-cycle wishbone answer and a 2-flop input synchroniser
`timescale 1ns/10ps
module level_limit_timer_test;
	logic clk, rst, cyc, stb, we, ack, ers, pwm, match, act, hi_lvl;
	logic [4:0]  adr;
	logic [31:0] dat, rdat;
	logic [7:0]  q;
	int n_fail = 0;
	int n_checks = 0;
	int n;
	logic [4:0] offs [8] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18, 5'h1C};
	// status after reset: source idles high, so the synced input reads 1
	logic [7:0] rstv [8] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
	level_limit_timer u_dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(rdat),
		.ack_o(ack), .external_reset_input_i(ers), .pwm_o(pwm),
		.period_match_o(match));
	hlt_ers_src u_src (.clk_i(clk), .active_i(act), .high_i(hi_lvl), .ers_o(ers));
	task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
		// leading edge also gives the idle cycle between two requests
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h00_0000, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0; stb <= 1'b0;
	endtask : bus
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic gap();
		do @(posedge clk); while (match !== 1'b1);
		n = 0;
		do begin @(posedge clk); n++; end while (match !== 1'b1 && n < 300);
	endtask : gap
	task automatic stop_test();
		if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#200000;
		n_fail++;
		stop_test();
	end
	initial
	begin
		{rst, cyc, stb, we, act, hi_lvl} = 6'b100000; adr = 0; dat = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (offs[i]) begin bus(offs[i], 0, 0); chk(q, rstv[i]); end
		bus(5'h04, 1, 8'h09); bus(5'h18, 1, 8'h03); bus(5'h08, 1, 8'h80);
		gap(); chk(n[7:0], 8'd10);
		chk({7'h00, pwm}, 8'h01);
		repeat (4) @(posedge clk);
		chk({7'h00, pwm}, 8'h00);
		bus(5'h0C, 1, 8'h06); act <= 1; repeat (30) @(posedge clk);
		bus(5'h00, 0, 0); chk(q, 8'h00);
		act <= 0; gap(); chk(n[7:0], 8'd10);
		bus(5'h18, 1, 8'h08); hi_lvl <= 1; bus(5'h0C, 1, 8'h07);
		do @(posedge clk); while (match !== 1'b1);
		act <= 1; repeat (30) @(posedge clk);
		chk({7'h00, pwm}, 8'h01);
		bus(5'h00, 0, 0); chk(q, 8'h00);
		bus(5'h08, 1, 8'h00); bus(5'h00, 1, 8'h05); repeat (20) @(posedge clk);
		bus(5'h00, 0, 0); chk(q, 8'h05);
		stop_test();
	end
endmodule : level_limit_timer_test
bind level_limit_timer hlt_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
	.external_reset_input_i(external_reset_input_i), .pwm_o(pwm_o),
	.period_match_o(period_match_o));
